// ---- src/bpc_command_handler.sv ----
// Command packet parser and reply sender of the serial boot protocol
`timescale 1ns/1ns

// Functional notes
// - Discard bytes until start-of-header arrives
// - Missing end byte gives packet error
// - Checksum mismatch gives checksum error
// - Length above format maximum gives packet error; zero length is dropped without reply
// - Length wrong for command gives packet error
// - On any error, skip execution, wait again
// - Readback refused by lifecycle: acceptance error
// - Readback at auth level one/zero: secure error
// - Readback reply 81h, 00h/05h, 4Dh, config bytes
// - Readback leaves memory unchanged, waits again
// - Error reply 00h/0Ah, code, status, FF fields
// - Report only highest-priority error, fixed order
// - Inquiry refused after encrypted write: acceptance
// - Inquiry OK reply, checksum FEh, no change
// - Signature reply 00h/2Ah, 3Ah, high byte first
module bpc_command_handler (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Received bytes from the host
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  // Reply bytes to the host
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  // Device state
  input wire logic lifecycleAllowsCfgRead,
  input wire logic [1:0] authLevel,
  input wire logic encWritePending,
  // Device data
  input wire logic [31:0] rollbackConfig,
  input wire bpc_pkg::bpc_sig_s sigInfo
);

  typedef enum logic [3:0] {
    ST_WAIT_SOH,
    ST_LEN_HI,
    ST_LEN_LO,
    ST_CMD,
    ST_DATA,
    ST_SUM,
    ST_ETX,
    ST_TX_FETCH,
    ST_TX_LOAD,
    ST_TX_SEND
  } bpc_state_e;

  bpc_state_e state;
  bpc_state_e next_state;
  logic [15:0] rxLen;
  logic [15:0] remain;
  logic [7:0] cmdCode;
  logic [7:0] rxSum;
  logic [7:0] txSum;
  logic [5:0] txIdx;
  bpc_pkg::bpc_reply_s reply;
  logic [7:0] romByte;

  // Receive side decode
  wire rxPhase = (state != ST_TX_FETCH) && (state != ST_TX_LOAD) &&
                 (state != ST_TX_SEND);
  wire rxTake = rxValid && rxPhase;
  wire [7:0] sumWithByte = rxSum + rxData;
  wire [15:0] lenFull = {rxLen[15:8], rxData};

  // Packet checks, evaluated when the byte after the checksum arrives
  wire etxMissing = rxData != bpc_pkg::BPC_ETX;
  wire checksumBad = rxSum != 8'h00;
  wire fmtBad = (rxLen == 16'h0000) ||
                (rxLen > bpc_pkg::BPC_LEN_FMT_MAX);
  wire cmdLenBad = rxLen != bpc_pkg::BPC_LEN_CMD_SHORT;
  wire isCfgRead = cmdCode == bpc_pkg::BPC_CMD_CFG_READ;
  wire isInq = cmdCode == bpc_pkg::BPC_CMD_INQUIRY;
  wire isSig = cmdCode == bpc_pkg::BPC_CMD_SIGNATURE;
  // Commands outside this block are dropped without a reply
  wire known = (rxLen != 16'h0000) && (isCfgRead || isInq || isSig);
  wire cfgDenied = isCfgRead && !lifecycleAllowsCfgRead;
  wire cfgSecure = isCfgRead &&
    ((authLevel == bpc_pkg::BPC_AUTH_LEVEL_ONE) ||
     (authLevel == bpc_pkg::BPC_AUTH_LEVEL_ZERO));
  wire encBlocked = (isInq || isSig) && encWritePending;
  wire anyErr = etxMissing || checksumBad || fmtBad || cmdLenBad ||
                cfgDenied || cfgSecure || encBlocked;
  // Earlier terms win
  wire [7:0] errStatus =
    etxMissing ? bpc_pkg::BPC_STATUS_PACKET :
    checksumBad ? bpc_pkg::BPC_STATUS_CHECKSUM :
    fmtBad ? bpc_pkg::BPC_STATUS_PACKET :
    cmdLenBad ? bpc_pkg::BPC_STATUS_PACKET :
    (cfgDenied || encBlocked) ? bpc_pkg::BPC_STATUS_ACCEPT :
    bpc_pkg::BPC_STATUS_SECURE;
  wire [7:0] errResp =
    isCfgRead ? bpc_pkg::BPC_ERR_CFG_READ :
    isInq ? bpc_pkg::BPC_ERR_INQUIRY : bpc_pkg::BPC_ERR_SIGNATURE;
  wire bpc_pkg::bpc_reply_e okKind =
    isCfgRead ? bpc_pkg::BPC_RPL_CFG :
    isInq ? bpc_pkg::BPC_RPL_INQ_OK : bpc_pkg::BPC_RPL_SIG;
  wire [7:0] okResp = cmdCode;
  // Patterns get their type from the declaration, not from a ternary
  wire bpc_pkg::bpc_reply_s errReply = '{kind: bpc_pkg::BPC_RPL_ERR,
    respCode: errResp, statusCode: errStatus};
  wire bpc_pkg::bpc_reply_s okReply = '{kind: okKind, respCode: okResp,
    statusCode: bpc_pkg::BPC_STATUS_OK};
  wire bpc_pkg::bpc_reply_s decided = anyErr ? errReply : okReply;

  // Transmit side decode
  wire [5:0] txLen = 6'(bpc_pkg::bpc_reply_len(reply.kind));
  wire [5:0] sumIdx = txLen + 6'd3;
  wire [5:0] etxIdx = txLen + 6'd4;
  wire [7:0] loadByte =
    (txIdx == 6'd0) ? bpc_pkg::BPC_REPLY_START :
    (txIdx == sumIdx) ? 8'h00 - txSum :
    (txIdx == etxIdx) ? bpc_pkg::BPC_ETX : romByte;
  wire txDone = txValid && txReady;
  wire sumCounts = (txIdx != 6'd0) && (txIdx < sumIdx);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_WAIT_SOH: begin
        if (rxTake && rxData == bpc_pkg::BPC_SOH) begin
          next_state = ST_LEN_HI;
        end
      end
      ST_LEN_HI: begin
        if (rxTake) begin
          next_state = ST_LEN_LO;
        end
      end
      ST_LEN_LO: begin
        if (rxTake) begin
          next_state = (lenFull == 16'h0000) ? ST_SUM : ST_CMD;
        end
      end
      ST_CMD: begin
        if (rxTake) begin
          next_state = (rxLen == 16'h0001) ? ST_SUM : ST_DATA;
        end
      end
      ST_DATA: begin
        if (rxTake && remain == 16'h0001) begin
          next_state = ST_SUM;
        end
      end
      ST_SUM: begin
        if (rxTake) begin
          next_state = ST_ETX;
        end
      end
      ST_ETX: begin
        // Errors never touch device memory; the handler only reads
        if (rxTake) begin
          next_state = known ? ST_TX_FETCH : ST_WAIT_SOH;
        end
      end
      ST_TX_FETCH: next_state = ST_TX_LOAD;
      ST_TX_LOAD: next_state = ST_TX_SEND;
      ST_TX_SEND: begin
        if (txDone) begin
          next_state = (txIdx == etxIdx) ? ST_WAIT_SOH :
                       ST_TX_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_WAIT_SOH;
    end else begin
      state <= next_state;
    end
  end

  // Receive bookkeeping
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxLen <= 16'h0000;
      remain <= 16'h0000;
      cmdCode <= 8'h00;
      rxSum <= 8'h00;
    end else if (rxTake) begin
      rxSum <= (state == ST_WAIT_SOH) ? 8'h00 : sumWithByte;
      if (state == ST_LEN_HI) begin
        rxLen <= {rxData, 8'h00};
      end
      if (state == ST_LEN_LO) begin
        rxLen <= lenFull;
        remain <= lenFull - 16'h0001;
      end
      if (state == ST_CMD) begin
        cmdCode <= rxData;
      end
      if (state == ST_DATA) begin
        remain <= remain - 16'h0001;
      end
    end
  end

  // Reply selection is frozen for the whole reply
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reply <= '{kind: bpc_pkg::BPC_RPL_ERR, respCode: 8'h00,
                 statusCode: 8'h00};
    end else if (state == ST_ETX && rxTake) begin
      reply <= decided;
    end
  end

  // Reply byte stepping
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txIdx <= 6'd0;
      txSum <= 8'h00;
      txData <= 8'h00;
      txValid <= 1'b0;
    end else begin
      if (state == ST_ETX) begin
        txIdx <= 6'd0;
        txSum <= 8'h00;
      end
      if (state == ST_TX_LOAD) begin
        txData <= loadByte;
        txValid <= 1'b1;
      end
      if (state == ST_TX_SEND && txDone) begin
        txValid <= 1'b0;
        txIdx <= txIdx + 6'd1;
        if (sumCounts) begin
          txSum <= txSum + txData;
        end
      end
    end
  end

  bpc_reply_bytes replyRom (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .byteIdx(txIdx),
    .reply(reply),
    .rollbackConfig(rollbackConfig),
    .sigInfo(sigInfo),
    .replyByte(romByte)
  );

endmodule

// ---- src/bpc_pkg.sv ----
// Shared constants and types of the boot packet command handler
package bpc_pkg;

  // Framing bytes
  localparam logic [7:0] BPC_SOH = 8'h01;
  localparam logic [7:0] BPC_ETX = 8'h03;
  localparam logic [7:0] BPC_REPLY_START = 8'h81;
  localparam logic [7:0] BPC_LEN_HI = 8'h00;
  localparam logic [7:0] BPC_UNUSED = 8'hFF;

  // Command codes and matching error response codes
  localparam logic [7:0] BPC_CMD_CFG_READ = 8'h4D;
  localparam logic [7:0] BPC_CMD_INQUIRY = 8'h00;
  localparam logic [7:0] BPC_CMD_SIGNATURE = 8'h3A;
  localparam logic [7:0] BPC_ERR_CFG_READ = 8'hCD;
  localparam logic [7:0] BPC_ERR_INQUIRY = 8'h80;
  localparam logic [7:0] BPC_ERR_SIGNATURE = 8'hBA;

  // Lengths, counted from the command or response byte
  localparam logic [15:0] BPC_LEN_CMD_SHORT = 16'h0001;
  localparam logic [15:0] BPC_LEN_FMT_MAX = 16'h0401;
  localparam logic [7:0] BPC_LEN_CFG_OK = 8'h05;
  localparam logic [7:0] BPC_LEN_STATUS = 8'h0A;
  localparam logic [7:0] BPC_LEN_SIG = 8'h2A;
  localparam int BPC_SIG_BYTES = 41;

  // Status byte codes
  localparam logic [7:0] BPC_STATUS_OK = 8'h00;
  localparam logic [7:0] BPC_STATUS_PACKET = 8'hC1;
  localparam logic [7:0] BPC_STATUS_CHECKSUM = 8'hC2;
  localparam logic [7:0] BPC_STATUS_ACCEPT = 8'hC3;
  localparam logic [7:0] BPC_STATUS_SECURE = 8'hC4;

  // Authentication level codes
  localparam logic [1:0] BPC_AUTH_LEVEL_ZERO = 2'h0;
  localparam logic [1:0] BPC_AUTH_LEVEL_ONE = 2'h1;

  typedef enum logic [1:0] {
    BPC_RPL_CFG,
    BPC_RPL_INQ_OK,
    BPC_RPL_SIG,
    BPC_RPL_ERR
  } bpc_reply_e;

  typedef struct packed {
    bpc_reply_e kind;
    logic [7:0] respCode;
    logic [7:0] statusCode;
  } bpc_reply_s;

  // Signature fields, first transmitted byte in the top bits
  typedef struct packed {
    logic [31:0] maxBaud;
    logic [7:0] areaCount;
    logic [7:0] typeCode;
    logic [23:0] bootVersion;
    logic [127:0] deviceId;
    logic [127:0] productName;
  } bpc_sig_s;

  function automatic logic [7:0] bpc_reply_len(input bpc_reply_e kind);
    logic [7:0] len;
    len = BPC_LEN_STATUS;
    if (kind == BPC_RPL_CFG) begin
      len = BPC_LEN_CFG_OK;
    end else if (kind == BPC_RPL_SIG) begin
      len = BPC_LEN_SIG;
    end
    return len;
  endfunction

endpackage

// ---- src/bpc_reply_bytes.sv ----
// Registered byte source for the body of a reply packet
`timescale 1ns/1ns
module bpc_reply_bytes (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Selection
  input wire logic [5:0] byteIdx,
  input wire bpc_pkg::bpc_reply_s reply,
  // Device data
  input wire logic [31:0] rollbackConfig,
  input wire bpc_pkg::bpc_sig_s sigInfo,
  // Byte at byteIdx, one cycle later
  output logic [7:0] replyByte
);

  wire [5:0] payIdx = byteIdx - 6'd4;
  wire [7:0] cfgByte = rollbackConfig[8 * int'(payIdx[1:0]) +: 8];
  wire sigInRange = int'(payIdx) < bpc_pkg::BPC_SIG_BYTES;
  wire [7:0] sigByte = sigInRange ?
    sigInfo[8 * (bpc_pkg::BPC_SIG_BYTES - 1 - int'(payIdx)) +: 8] :
    bpc_pkg::BPC_UNUSED;
  wire [7:0] statByte = (payIdx == 6'd0) ? reply.statusCode :
    bpc_pkg::BPC_UNUSED;
  wire [7:0] payByte =
    (reply.kind == bpc_pkg::BPC_RPL_CFG) ? cfgByte :
    (reply.kind == bpc_pkg::BPC_RPL_SIG) ? sigByte : statByte;
  wire [7:0] next_replyByte =
    (byteIdx == 6'd1) ? bpc_pkg::BPC_LEN_HI :
    (byteIdx == 6'd2) ? bpc_pkg::bpc_reply_len(reply.kind) :
    (byteIdx == 6'd3) ? reply.respCode : payByte;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      replyByte <= 8'h00;
    end else begin
      replyByte <= next_replyByte;
    end
  end

endmodule

// ---- verification/bpc_command_handler_bench.sv ----
// Self-checking bench of the boot packet command handler
`timescale 1ns/1ns
module bpc_command_handler_bench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] rxData;
  logic rxValid;
  logic [7:0] txData;
  logic txValid;
  logic txReady;
  logic lcOk = 1'b1;
  logic [1:0] auth = 2'h2;
  logic encPend = 1'b0;
  logic [31:0] cfgData = 32'h44332211;
  bpc_pkg::bpc_sig_s sig;
  int bad_count = 0;
  int cmp_count = 0;
  bpc_command_handler DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .rxData(rxData), .rxValid(rxValid), .txData(txData),
    .txValid(txValid), .txReady(txReady), .lifecycleAllowsCfgRead(lcOk),
    .authLevel(auth), .encWritePending(encPend),
    .rollbackConfig(cfgData),
    .sigInfo(sig));
  bpc_host_model host (.clk_sys(clk_sys), .rxData(rxData),
    .rxValid(rxValid), .txData(txData), .txValid(txValid),
    .txReady(txReady));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b[$], input logic [7:0] etx = 8'h03,
    input logic [7:0] adj = 8'h00);
    logic [7:0] s;
    s = adj;
    foreach (b[i]) s -= b[i];
    host.send({8'h01, b, s, etx});
  endtask
  task automatic reply(input logic [7:0] lenLow, resp,
    input logic [7:0] pl[$]);
    logic [7:0] e[$];
    logic [7:0] s;
    int n;
    e = {8'h81, 8'h00, lenLow, resp, pl};
    s = 8'h00;
    foreach (e[i]) s -= (i > 0) ? e[i] : 8'h00;
    e.push_back(s);
    e.push_back(8'h03);
    n = 0;
    while (host.got.size() < e.size()) begin
      @(negedge clk_sys);
      n++;
      if (n > 3000) begin
        bad_count++;
        end_sim();
      end
    end
    repeat (12) @(negedge clk_sys);
    check("reply size", 8'(host.got.size()), 8'(e.size()));
    foreach (e[i]) check("reply byte", host.got[i], e[i]);
    host.got.delete();
  endtask
  task automatic err(input logic [7:0] resp, status);
    logic [7:0] pl[$];
    pl = {status};
    repeat (8) pl.push_back(8'hFF);
    reply(8'h0A, resp, pl);
  endtask
  task automatic t_inquiry();
    check("reset txValid", {7'h00, txValid}, 8'h00);
    check("reset txData", txData, 8'h00);
    host.send({8'h55, 8'h03});
    host.send({8'h01, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h03});
    err(8'h00, 8'h00);
  endtask
  task automatic t_cfg_read();
    host.slow = 1'b1;
    cmd({8'h00, 8'h01, 8'h4D});
    reply(8'h05, 8'h4D, {8'h11, 8'h22, 8'h33, 8'h44});
    cmd({8'h00, 8'h01, 8'h4D});
    reply(8'h05, 8'h4D, {8'h11, 8'h22, 8'h33, 8'h44});
    host.slow = 1'b0;
  endtask
  task automatic t_accept();
    logic [2:0] m[4] = '{3'h2, 3'h0, 3'h5, 3'h4};
    foreach (m[i]) begin
      {lcOk, auth} = m[i];
      cmd({8'h00, 8'h01, 8'h4D});
      err(8'hCD, m[i][2] ? 8'hC4 : 8'hC3);
    end
    {lcOk, auth} = 3'h6;
  endtask
  task automatic t_frame();
    logic [7:0] b[$];
    cmd({8'h00, 8'h01, 8'h00}, 8'h04);
    err(8'h80, 8'hC1);
    cmd({8'h00, 8'h01, 8'h00}, 8'h00, 8'h01);
    err(8'h80, 8'hC1);
    cmd({8'h00, 8'h01, 8'h00}, 8'h03, 8'h01);
    err(8'h80, 8'hC2);
    cmd({8'h00, 8'h02, 8'h00, 8'h00}, 8'h03, 8'h01);
    err(8'h80, 8'hC2);
    cmd({8'h00, 8'h02, 8'h00, 8'h00});
    err(8'h80, 8'hC1);
    b = {8'h04, 8'h02, 8'h00};
    repeat (1025) b.push_back(8'h00);
    cmd(b);
    err(8'h80, 8'hC1);
    cmd({8'h00, 8'h01, 8'h00});
    err(8'h00, 8'h00);
  endtask
  task automatic t_enc();
    encPend = 1'b1;
    cmd({8'h00, 8'h01, 8'h00});
    err(8'h80, 8'hC3);
    cmd({8'h00, 8'h01, 8'h3A});
    err(8'hBA, 8'hC3);
    encPend = 1'b0;
  endtask
  task automatic t_sig();
    logic [7:0] pl[$];
    for (int i = 0; i < 41; i++) pl.push_back(8'h10 + 8'(i));
    host.send({8'h01, 8'h00, 8'h01, 8'h3A, 8'hC5, 8'h03});
    reply(8'h2A, 8'h3A, pl);
  endtask
  initial begin
    for (int i = 0; i < 41; i++) begin
      sig[327 - 8 * i -: 8] = 8'h10 + 8'(i);
    end
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    t_inquiry();
    t_cfg_read();
    t_accept();
    t_frame();
    t_enc();
    t_sig();
    end_sim();
  end
endmodule

// ---- verification/bpc_handler_chk.sv ----
// Reply framing checker for the boot packet command handler
`timescale 1ns/1ns
module bpc_handler_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Links
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady
);
  logic [5:0] idx;
  logic [7:0] lenLow;
  logic [7:0] sum;
  wire take = txValid && txReady;
  // Length byte is stale before index 3, so it is not trusted there
  wire last = idx > 6'h02 && idx == 6'(lenLow) + 6'h04;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idx <= 6'h00;
      lenLow <= 8'h00;
      sum <= 8'h00;
    end else if (take) begin
      idx <= last ? 6'h00 : idx + 6'h01;
      lenLow <= (idx == 6'h02) ? txData : lenLow;
      sum <= (idx == 6'h00) ? 8'h00 : sum + txData;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_start_byte: assert property (
    txValid && idx == 6'h00 |-> txData == 8'h81) else $error("bad start");
  chk_length_low: assert property (
    txValid && idx == 6'h02 |-> txData inside {8'h05, 8'h0A, 8'h2A})
    else $error("bad length");
  chk_cfg_code: assert property (
    txValid && idx == 6'h03 && lenLow == 8'h05 |-> txData == 8'h4D)
    else $error("bad readback code");
  chk_unused_fields: assert property (
    txValid && lenLow == 8'h0A && idx > 6'h04 && idx < 6'h0D
    |-> txData == 8'hFF) else $error("bad unused field");
  chk_sum_zero: assert property (
    txValid && idx > 6'h02 && idx == 6'(lenLow) + 6'h03
    |-> 8'(sum + txData) == 8'h00) else $error("bad checksum");
  chk_end_byte: assert property (
    txValid && last |-> txData == 8'h03) else $error("bad end byte");
  chk_byte_gap: assert property (
    take |=> !txValid [*2]) else $error("bad byte gap");
  chk_reply_cause: assert property (
    $rose(txValid) && idx == 6'h00 |-> $past(rxValid, 3))
    else $error("reply without packet end");
  cov_inquiry: cover property (take && idx == 6'h03 && lenLow == 8'h0A);
  cov_cfg_read: cover property (take && idx == 6'h03 && txData == 8'h4D);
  cov_sig: cover property (take && idx == 6'h02 && txData == 8'h2A);
endmodule

bind bpc_command_handler bpc_handler_chk u_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .rxData(rxData), .rxValid(rxValid),
  .txData(txData), .txValid(txValid), .txReady(txReady));

// ---- verification/bpc_host_model.sv ----
// Host model: sends command packets, collects reply bytes
`timescale 1ns/1ns
module bpc_host_model (
  // Clock
  input wire logic clk_sys,
  // Command bytes to the device
  output logic [7:0] rxData,
  output logic rxValid,
  // Reply bytes from the device
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  logic [7:0] got[$];
  logic slow = 1'b0;
  logic [1:0] ph = 2'h0;
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b1;
  end
  // Slow host stalls three cycles of four
  always @(negedge clk_sys) begin
    ph <= ph + 2'h1;
    txReady <= !slow || ph == 2'h3;
  end
  always @(posedge clk_sys) begin
    if (txValid && txReady) begin
      got.push_back(txData);
    end
  end
  task automatic send(input logic [7:0] p[$]);
    foreach (p[i]) begin
      @(negedge clk_sys);
      rxValid <= 1'b1;
      rxData <= p[i];
    end
    @(negedge clk_sys);
    rxValid <= 1'b0;
    // Released line shows no stale byte
    rxData <= ~rxData;
  endtask
endmodule
